// file: rtl/radio_ctrl_pkg.sv
// Constants, codes and carrier types for the radio state control block
package radio_ctrl_pkg;
  localparam int CLOCK_PERIOD_NS = 100;
  localparam int SYM_NS_BPSK20 = 50000;
  localparam int SYM_NS_BPSK40 = 25000;
  localparam int SYM_NS_OQPSK_LOW = 40000;
  localparam int SYM_NS_OQPSK_HIGH = 16000;
  localparam int LEAD_STEP_NS = 2000;
  localparam int RAMP_STEP_NS = 1000;
  localparam logic [9:0] SYM_CYC_BPSK20 = 10'((SYM_NS_BPSK20 + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS);
  localparam logic [9:0] SYM_CYC_BPSK40 = 10'((SYM_NS_BPSK40 + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS);
  localparam logic [9:0] SYM_CYC_OQPSK_LOW = 10'((SYM_NS_OQPSK_LOW + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS);
  localparam logic [9:0] SYM_CYC_OQPSK_HIGH = 10'((SYM_NS_OQPSK_HIGH + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS);
  localparam logic [9:0] LEAD_STEP_CYC = 10'((LEAD_STEP_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS);
  localparam logic [3:0] RAMP_STEP_LAST = 4'((RAMP_STEP_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS - 1);
  // Register word indices, byte address is four times the index
  localparam logic [5:0] IDX_STATE_CODE = 6'h01;
  localparam logic [5:0] IDX_STATE_CTRL = 6'h02;
  localparam logic [5:0] IDX_TX_POWER = 6'h05;
  localparam logic [5:0] IDX_CTRL_TWO = 6'h0c;
  localparam logic [5:0] IDX_SYNC_CTRL = 6'h15;
  localparam logic [5:0] IDX_RF_CTRL = 6'h16;
  localparam logic [7:0] RST_CTRL_TWO = 8'h00;
  localparam logic [7:0] RST_SYNC_CTRL = 8'h00;
  localparam logic [7:0] RST_RF_CTRL = 8'h00;
  localparam logic [7:0] RST_TX_POWER = 8'h00;
  localparam logic [4:0] RST_CMD = 5'h00;
  // Field positions
  localparam int P_SAFE_MODE = 7;
  localparam int P_PHY_MODE = 0;
  localparam int P_SYNC_DIS = 7;
  localparam int P_SYNC_THR = 0;
  localparam int P_LEAD_TIME = 6;
  localparam int P_BOOST = 2;
  localparam int P_GAIN_OFFS = 0;
  localparam int P_GAIN = 5;
  localparam int P_POWER = 0;
  localparam int P_CMD = 0;
  // Commands and state codes
  localparam logic [4:0] CMD_TX_START = 5'h02;
  localparam logic [4:0] CMD_RX_ON = 5'h06;
  localparam logic [4:0] CMD_TRANSCEIVER_OFF_STATE = 5'h08;
  localparam logic [4:0] CMD_PLL_ON = 5'h09;
  localparam logic [4:0] CMD_AACK = 5'h16;
  localparam logic [4:0] CMD_ARET = 5'h19;
  localparam logic [4:0] CODE_BUSY_RX = 5'h01;
  localparam logic [4:0] CODE_BUSY_TX = 5'h02;
  localparam logic [4:0] CODE_RX_ON = 5'h06;
  localparam logic [4:0] CODE_OFF = 5'h08;
  localparam logic [4:0] CODE_PLL_ON = 5'h09;
  localparam logic [4:0] CODE_BUSY_AACK = 5'h11;
  localparam logic [4:0] CODE_BUSY_ARET = 5'h12;
  localparam logic [4:0] CODE_AACK_ON = 5'h16;
  localparam logic [4:0] CODE_ARET_ON = 5'h19;
  localparam logic signed [7:0] TX_MIN_DBM = -8'sd27;
  localparam logic signed [7:0] TX_MAX_DBM = TX_MIN_DBM + 8'sd31;
  typedef enum logic [3:0] {
    S_OFF, S_PLL, S_RX, S_RX_BUSY, S_AACK, S_AACK_BUSY, S_ARET, S_TX_START, S_TX_DATA, S_TX_DOWN
  } state_control_register_t;
  typedef struct packed {
    logic read;
    logic write;
    logic [7:0] address;
    logic [31:0] writedata;
  } avl_req_t;
endpackage : radio_ctrl_pkg

// file: rtl/pin_sync.sv
// Two-stage pin synchroniser with rising edge pulse
`timescale 1ns/100ps
module pin_sync (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic pin,
  output logic level,
  output logic rise
);
  logic meta_reg;
  logic sync_reg;
  logic last_reg;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      last_reg <= 1'b0;
    end else begin
      meta_reg <= pin;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end
  assign level = sync_reg;
  assign rise = sync_reg && !last_reg;
endmodule : pin_sync

// file: rtl/gain_ramp.sv
// Amplifier gain stepper toward a goal, one step per ramp interval
`timescale 1ns/100ps
module gain_ramp (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic raise,
  input wire logic [2:0] target,
  output logic [2:0] gain_reg
);
  logic [3:0] step_reg;
  wire [2:0] goal = raise ? target : 3'h0;
  wire step_due = step_reg == radio_ctrl_pkg::RAMP_STEP_LAST;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      step_reg <= 4'h0;
      gain_reg <= 3'h0;
    end else begin
      if (gain_reg == goal || step_due) begin
        step_reg <= 4'h0;
      end else begin
        step_reg <= step_reg + 4'h1;
      end
      if (step_due && gain_reg < goal) begin
        gain_reg <= gain_reg + 3'h1;
      end else if (step_due && gain_reg > goal) begin
        gain_reg <= gain_reg - 3'h1;
      end
    end
  end
endmodule : gain_ramp

// file: rtl/radio_state_ctrl.sv
// Receive and transmit state control with Avalon-MM register slave
//
// The implementer's own choice: the Avalon-MM slave port.
`timescale 1ns/100ps
// How it works
// [RULE_01] Listen command enters receive from off/idle
// [RULE_02] Auto-ack command enters auto-ack receive from idle
// [RULE_03] Interference level sampled throughout frame decoding
// [RULE_04] Strong interferer restarts sync to new frame
// [RULE_05] Weak signals below threshold never demodulated
// [RULE_06] Safe mode holds listen until frame uploaded
// [RULE_07] Only frames with good FCS get protected
// [RULE_08] Sync disable bit blocks every further header
// [RULE_09] Transmit by command or sleep/transmit pin edge
// [RULE_10] Extended modes launch transmissions automatically; here only auto-ack mode does (the acknowledgement), ARET needs a trigger
// [RULE_11] Data starts one symbol after trigger
// [RULE_12] Amplifier switched on lead time before data
// [RULE_13] Amplifier gain starts zero, ramps to setting
// [RULE_14] Ramp down in reverse order after transmit
// [RULE_15] Trigger moves idle state to transmitting
// [RULE_16] Boost mode turns the equalizer off
// [RULE_17] Power level sets 1 dB steps, -27 dBm floor
// [RULE_18] Symbol period follows selected modulation mode
// [RULE_19] Sync moves listen to receiving and back
// [RULE_20] Commands illegal in current state are ignored
module radio_state_ctrl (
  input wire logic clock,
  input wire logic rst_b,
  input wire radio_ctrl_pkg::avl_req_t avl_req,
  output logic [31:0] avl_readdata,
  output logic avl_waitrequest,
  input wire logic sleep_transmit_pin,
  input wire logic sel_b,
  input wire logic frame_read_active,
  input wire logic sync_found,
  input wire logic [3:0] rssi_level,
  input wire logic [3:0] interference_level,
  input wire logic frame_done,
  input wire logic fcs_valid,
  input wire logic ack_request,
  input wire logic tx_done,
  output logic rx_enable,
  output logic demod_active,
  output logic override_pulse,
  output logic frame_protected,
  output logic tx_blocks_on,
  output logic amp_on,
  output logic [2:0] amp_gain,
  output logic tx_data_en,
  output logic eq_enable,
  output logic signed [7:0] tx_power_dbm,
  output logic [1:0] tx_gain_offset
);
  radio_ctrl_pkg::state_control_register_t state_reg;
  radio_ctrl_pkg::state_control_register_t state_next;
  radio_ctrl_pkg::state_control_register_t ret_reg;
  radio_ctrl_pkg::state_control_register_t ret_next;
  logic [4:0] cmd_reg;
  logic [7:0] ctrl_two_reg;
  logic [7:0] sync_ctrl_reg;
  logic [7:0] rf_ctrl_reg;
  logic [7:0] tx_power_reg;
  logic [9:0] cnt_reg;
  logic [3:0] intf_reg;
  logic [3:0] frame_rssi_reg;
  logic pin_rise;
  logic sel_rise;

  // Bus handshake: one wait cycle, then answer
  wire req = avl_req.read || avl_req.write;
  wire take = req && !avl_waitrequest;
  wire wr_take = take && avl_req.write;
  wire [5:0] idx = avl_req.address[7:2];
  wire [7:0] wdata = avl_req.writedata[7:0];
  wire [4:0] code_now;
  wire [7:0] rd_data =
    (idx == radio_ctrl_pkg::IDX_STATE_CODE) ? {3'h0, code_now} :
    (idx == radio_ctrl_pkg::IDX_STATE_CTRL) ? {3'h0, cmd_reg} :
    (idx == radio_ctrl_pkg::IDX_TX_POWER) ? tx_power_reg :
    (idx == radio_ctrl_pkg::IDX_CTRL_TWO) ? ctrl_two_reg :
    (idx == radio_ctrl_pkg::IDX_SYNC_CTRL) ? sync_ctrl_reg :
    (idx == radio_ctrl_pkg::IDX_RF_CTRL) ? rf_ctrl_reg : 8'h00;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      avl_waitrequest <= 1'b1;
      avl_readdata <= 32'h0000_0000;
    end else begin
      avl_waitrequest <= !(req && avl_waitrequest);
      if (req && avl_waitrequest) begin
        avl_readdata <= {24'h00_0000, rd_data};
      end
    end
  end

  // Configuration registers
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cmd_reg <= radio_ctrl_pkg::RST_CMD;
      ctrl_two_reg <= radio_ctrl_pkg::RST_CTRL_TWO;
      sync_ctrl_reg <= radio_ctrl_pkg::RST_SYNC_CTRL;
      rf_ctrl_reg <= radio_ctrl_pkg::RST_RF_CTRL;
      tx_power_reg <= radio_ctrl_pkg::RST_TX_POWER;
    end else if (wr_take) begin
      if (idx == radio_ctrl_pkg::IDX_STATE_CTRL) cmd_reg <= wdata[radio_ctrl_pkg::P_CMD +: 5];
      if (idx == radio_ctrl_pkg::IDX_CTRL_TWO) ctrl_two_reg <= wdata;
      if (idx == radio_ctrl_pkg::IDX_SYNC_CTRL) sync_ctrl_reg <= wdata;
      if (idx == radio_ctrl_pkg::IDX_RF_CTRL) rf_ctrl_reg <= wdata;
      if (idx == radio_ctrl_pkg::IDX_TX_POWER) tx_power_reg <= wdata;
    end
  end

  wire safe_mode = ctrl_two_reg[radio_ctrl_pkg::P_SAFE_MODE];
  wire [1:0] phy_mode = ctrl_two_reg[radio_ctrl_pkg::P_PHY_MODE +: 2];
  wire sync_dis = sync_ctrl_reg[radio_ctrl_pkg::P_SYNC_DIS];
  wire [3:0] sync_thr = sync_ctrl_reg[radio_ctrl_pkg::P_SYNC_THR +: 4];
  wire [1:0] amp_lt = rf_ctrl_reg[radio_ctrl_pkg::P_LEAD_TIME +: 2];
  wire boost = rf_ctrl_reg[radio_ctrl_pkg::P_BOOST];
  wire [2:0] gain_set = tx_power_reg[radio_ctrl_pkg::P_GAIN +: 3];
  wire [4:0] power_lvl = tx_power_reg[radio_ctrl_pkg::P_POWER +: 5];

  pin_sync u_slp_sync (
    .clock(clock),
    .rst_b(rst_b),
    .pin(sleep_transmit_pin),
    .level(),
    .rise(pin_rise)
  );
  pin_sync u_sel_sync (
    .clock(clock),
    .rst_b(rst_b),
    .pin(sel_b),
    .level(),
    .rise(sel_rise)
  );

  // Command decode
  wire cmd_wr = wr_take && idx == radio_ctrl_pkg::IDX_STATE_CTRL;
  wire [4:0] cmd = wdata[radio_ctrl_pkg::P_CMD +: 5];
  wire st_off = state_reg == radio_ctrl_pkg::S_OFF;
  wire st_pll = state_reg == radio_ctrl_pkg::S_PLL;
  wire st_listen = state_reg == radio_ctrl_pkg::S_RX || state_reg == radio_ctrl_pkg::S_AACK;
  wire st_busy = state_reg == radio_ctrl_pkg::S_RX_BUSY || state_reg == radio_ctrl_pkg::S_AACK_BUSY;
  wire st_aret = state_reg == radio_ctrl_pkg::S_ARET;
  wire st_settled = st_pll || st_listen || st_aret;
  // [RULE_01] [RULE_20] listen command gating
  wire cmd_rx_ok = cmd_wr && cmd == radio_ctrl_pkg::CMD_RX_ON && (st_off || st_pll);
  // [RULE_02] [RULE_20] auto-ack command gating
  wire cmd_aack_ok = cmd_wr && cmd == radio_ctrl_pkg::CMD_AACK && st_pll;
  wire cmd_aret_ok = cmd_wr && cmd == radio_ctrl_pkg::CMD_ARET && st_pll;
  wire cmd_pll_ok = cmd_wr && cmd == radio_ctrl_pkg::CMD_PLL_ON && (st_off || st_listen || st_aret);
  wire cmd_off_ok = cmd_wr && cmd == radio_ctrl_pkg::CMD_TRANSCEIVER_OFF_STATE && st_settled;
  wire cmd_move = cmd_rx_ok || cmd_aack_ok || cmd_aret_ok || cmd_pll_ok || cmd_off_ok;
  // [RULE_09] [RULE_20] command or pin edge, idle or ARET only
  wire tx_req = (cmd_wr && cmd == radio_ctrl_pkg::CMD_TX_START) || pin_rise;
  wire tx_trig_ok = tx_req && (st_pll || st_aret) && !cmd_move;
  // [RULE_10] automatic acknowledgement transmission
  wire auto_ack_tx = state_reg == radio_ctrl_pkg::S_AACK_BUSY && frame_done && fcs_valid && ack_request;

  // [RULE_05] [RULE_08] [RULE_06] sync acceptance
  wire sync_ok = sync_found && rssi_level >= sync_thr && !sync_dis && !frame_protected;
  // [RULE_04] interferer at least as strong as current frame
  wire override_ok = st_busy && !frame_done && sync_ok && intf_reg >= frame_rssi_reg;

  // [RULE_18] symbol length per mode
  wire [9:0] sym_cyc =
    (phy_mode == 2'h0) ? radio_ctrl_pkg::SYM_CYC_BPSK20 :
    (phy_mode == 2'h1) ? radio_ctrl_pkg::SYM_CYC_BPSK40 :
    (phy_mode == 2'h2) ? radio_ctrl_pkg::SYM_CYC_OQPSK_LOW : radio_ctrl_pkg::SYM_CYC_OQPSK_HIGH;
  wire [9:0] sym_last = sym_cyc - 10'h001;
  wire [9:0] lead_cyc = 10'(radio_ctrl_pkg::LEAD_STEP_CYC * ({8'h00, amp_lt} + 10'h001));
  wire st_tx_start = state_reg == radio_ctrl_pkg::S_TX_START;
  wire st_tx_down = state_reg == radio_ctrl_pkg::S_TX_DOWN;
  wire gain_zero = amp_gain == 3'h0;

  always_comb begin
    state_next = state_reg;
    ret_next = ret_reg;
    case (state_reg)
      radio_ctrl_pkg::S_OFF, radio_ctrl_pkg::S_PLL, radio_ctrl_pkg::S_ARET: begin
        if (cmd_rx_ok) state_next = radio_ctrl_pkg::S_RX;
        else if (cmd_aack_ok) state_next = radio_ctrl_pkg::S_AACK;
        else if (cmd_aret_ok) state_next = radio_ctrl_pkg::S_ARET;
        else if (cmd_pll_ok) state_next = radio_ctrl_pkg::S_PLL;
        else if (cmd_off_ok) state_next = radio_ctrl_pkg::S_OFF;
        // [RULE_15] idle to transmitting
        else if (tx_trig_ok) begin
          state_next = radio_ctrl_pkg::S_TX_START;
          ret_next = state_reg;
        end
      end
      radio_ctrl_pkg::S_RX, radio_ctrl_pkg::S_AACK: begin
        if (cmd_pll_ok) state_next = radio_ctrl_pkg::S_PLL;
        else if (cmd_off_ok) state_next = radio_ctrl_pkg::S_OFF;
        // [RULE_19] listen to receiving
        else if (sync_ok) begin
          state_next = (state_reg == radio_ctrl_pkg::S_RX) ?
            radio_ctrl_pkg::S_RX_BUSY : radio_ctrl_pkg::S_AACK_BUSY;
        end
      end
      radio_ctrl_pkg::S_RX_BUSY, radio_ctrl_pkg::S_AACK_BUSY: begin
        // [RULE_10] ack sent after good frame
        if (auto_ack_tx) begin
          state_next = radio_ctrl_pkg::S_TX_START;
          ret_next = radio_ctrl_pkg::S_AACK;
        // [RULE_19] back to listen after frame
        end else if (frame_done) begin
          state_next = (state_reg == radio_ctrl_pkg::S_RX_BUSY) ?
            radio_ctrl_pkg::S_RX : radio_ctrl_pkg::S_AACK;
        end
      end
      radio_ctrl_pkg::S_TX_START: begin
        // [RULE_11] data one symbol after trigger
        if (cnt_reg == sym_last) state_next = radio_ctrl_pkg::S_TX_DATA;
      end
      radio_ctrl_pkg::S_TX_DATA: begin
        if (tx_done) state_next = radio_ctrl_pkg::S_TX_DOWN;
      end
      radio_ctrl_pkg::S_TX_DOWN: begin
        // [RULE_14] blocks off last
        if (!amp_on) state_next = ret_reg;
      end
      default: state_next = radio_ctrl_pkg::S_OFF;
    endcase
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= radio_ctrl_pkg::S_OFF;
      ret_reg <= radio_ctrl_pkg::S_PLL;
    end else begin
      state_reg <= state_next;
      ret_reg <= ret_next;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cnt_reg <= 10'h000;
    end else if (st_tx_start) begin
      cnt_reg <= cnt_reg + 10'h001;
    end else begin
      cnt_reg <= 10'h000;
    end
  end

  // [RULE_03] interference tracked while decoding
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      intf_reg <= 4'h0;
      frame_rssi_reg <= 4'h0;
    end else begin
      intf_reg <= st_busy ? interference_level : 4'h0;
      if ((st_listen && sync_ok) || override_ok) frame_rssi_reg <= rssi_level;
    end
  end

  // Receive outputs
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rx_enable <= 1'b0;
      demod_active <= 1'b0;
      override_pulse <= 1'b0;
    end else begin
      rx_enable <= state_next inside {radio_ctrl_pkg::S_RX, radio_ctrl_pkg::S_AACK,
        radio_ctrl_pkg::S_RX_BUSY, radio_ctrl_pkg::S_AACK_BUSY};
      demod_active <= state_next inside {radio_ctrl_pkg::S_RX_BUSY,
        radio_ctrl_pkg::S_AACK_BUSY};
      override_pulse <= override_ok;
    end
  end

  // [RULE_06] [RULE_07] protect good frames until uploaded, set wins
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      frame_protected <= 1'b0;
    end else if (st_busy && frame_done && fcs_valid && safe_mode) begin
      frame_protected <= 1'b1;
    end else if ((sel_rise && frame_read_active) || !safe_mode) begin
      frame_protected <= 1'b0;
    end
  end

  // Transmit sequencing
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      tx_blocks_on <= 1'b0;
      amp_on <= 1'b0;
      tx_data_en <= 1'b0;
    end else begin
      tx_blocks_on <= state_next inside {radio_ctrl_pkg::S_TX_START,
        radio_ctrl_pkg::S_TX_DATA, radio_ctrl_pkg::S_TX_DOWN};
      tx_data_en <= state_next == radio_ctrl_pkg::S_TX_DATA;
      // [RULE_12] amplifier on ahead of data
      if (st_tx_start && cnt_reg >= sym_cyc - lead_cyc) amp_on <= 1'b1;
      // [RULE_14] amplifier off once gain is down
      else if (st_tx_down && gain_zero) amp_on <= 1'b0;
    end
  end

  // [RULE_13] gain stepped from zero to setting
  gain_ramp u_ramp (
    .clock(clock),
    .rst_b(rst_b),
    .raise(amp_on && !st_tx_down),
    .target(gain_set),
    .gain_reg(amp_gain)
  );

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      eq_enable <= 1'b1;
      tx_power_dbm <= radio_ctrl_pkg::TX_MAX_DBM;
      tx_gain_offset <= 2'h0;
    end else begin
      // [RULE_16] equalizer off in boost
      eq_enable <= !boost;
      // [RULE_17] one dB per level step
      tx_power_dbm <= radio_ctrl_pkg::TX_MAX_DBM - $signed({3'h0, power_lvl});
      tx_gain_offset <= rf_ctrl_reg[radio_ctrl_pkg::P_GAIN_OFFS +: 2];
    end
  end

  function automatic logic [4:0] state_code(radio_ctrl_pkg::state_control_register_t s,
                                            radio_ctrl_pkg::state_control_register_t r);
    case (s)
      radio_ctrl_pkg::S_OFF: state_code = radio_ctrl_pkg::CODE_OFF;
      radio_ctrl_pkg::S_PLL: state_code = radio_ctrl_pkg::CODE_PLL_ON;
      radio_ctrl_pkg::S_RX: state_code = radio_ctrl_pkg::CODE_RX_ON;
      radio_ctrl_pkg::S_RX_BUSY: state_code = radio_ctrl_pkg::CODE_BUSY_RX;
      radio_ctrl_pkg::S_AACK: state_code = radio_ctrl_pkg::CODE_AACK_ON;
      radio_ctrl_pkg::S_AACK_BUSY: state_code = radio_ctrl_pkg::CODE_BUSY_AACK;
      radio_ctrl_pkg::S_ARET: state_code = radio_ctrl_pkg::CODE_ARET_ON;
      default: state_code = (r == radio_ctrl_pkg::S_ARET) ? radio_ctrl_pkg::CODE_BUSY_ARET :
        (r == radio_ctrl_pkg::S_AACK) ? radio_ctrl_pkg::CODE_BUSY_AACK :
        radio_ctrl_pkg::CODE_BUSY_TX;
    endcase
  endfunction : state_code

  assign code_now = state_code(state_reg, ret_reg);

  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  a_rx_cmd_enter: assert property (cmd_rx_ok |=> state_reg == radio_ctrl_pkg::S_RX) // [RULE_01]
    else $error("listen command not taken");
  a_aack_cmd_enter: assert property (cmd_aack_ok |=> state_reg == radio_ctrl_pkg::S_AACK) // [RULE_02]
    else $error("auto-ack command not taken");
  a_override_fires: assert property (override_ok |=> override_pulse && demod_active) // [RULE_04]
    else $error("override missed");
  a_weak_sync_ignored: assert property (st_listen && sync_found && rssi_level < sync_thr
    && !cmd_move |=> st_listen) // [RULE_05]
    else $error("weak signal demodulated");
  a_protect_holds: assert property (frame_protected && st_listen && !cmd_move
    |=> st_listen) // [RULE_06]
    else $error("protected frame overwritten");
  a_bad_fcs_open: assert property (st_busy && frame_done && !fcs_valid
    |=> !frame_protected) // [RULE_07]
    else $error("bad frame protected");
  a_sync_dis_hold: assert property (sync_dis && st_listen && !cmd_move |=> st_listen) // [RULE_08]
    else $error("header taken while disabled");
  a_tx_trigger: assert property (tx_trig_ok |=> st_tx_start ##1 tx_blocks_on) // [RULE_15]
    else $error("trigger did not start transmit");
  a_data_symbol: assert property (st_tx_start && cnt_reg == sym_last
    |=> tx_data_en && $past(cnt_reg) == sym_cyc - 10'h001) // [RULE_11]
    else $error("data not one symbol after trigger");
  a_amp_before_data: assert property ($rose(tx_data_en) |-> amp_on) // [RULE_12]
    else $error("amplifier late");
  a_gain_from_zero: assert property ($rose(amp_on) |-> gain_zero ##1 amp_gain <= gain_set) // [RULE_13]
    else $error("gain not from zero");
  a_ramp_reverse: assert property ($fell(amp_on) |-> gain_zero && tx_blocks_on && !tx_data_en) // [RULE_14]
    else $error("ramp down order wrong");
  a_eq_boost: assert property (boost |=> !eq_enable) // [RULE_16]
    else $error("equalizer on in boost");
  a_power_floor: assert property (tx_power_dbm >= radio_ctrl_pkg::TX_MIN_DBM) // [RULE_17]
    else $error("power below floor");
  c_rx_frame: cover property (st_listen && sync_ok ##[1:50] st_busy && frame_done);
  c_override: cover property (override_pulse);
  c_tx_full: cover property (tx_trig_ok ##[1:600] $fell(tx_blocks_on));
  c_auto_ack: cover property (auto_ack_tx);
endmodule : radio_state_ctrl

// file: dv/host_model.sv
// Host side of frame upload: select line and frame-read access
`timescale 1ns/100ps
module host_model (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic upload,
  output logic sel_b,
  output logic frame_read_active
);
  logic [4:0] cnt_reg;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cnt_reg <= 5'h00;
    end else if (upload) begin
      cnt_reg <= 5'h14;
    end else if (cnt_reg != 5'h00) begin
      cnt_reg <= cnt_reg - 5'h01;
    end
  end
  assign sel_b = !(cnt_reg > 5'h08);
  assign frame_read_active = (cnt_reg != 5'h00);
endmodule : host_model

// file: dv/radio_rx_tx_state_control_tb.sv
// Self-checking bench for the radio state control block
`timescale 1ns/100ps
module radio_rx_tx_state_control_tb;
  localparam int CP = radio_ctrl_pkg::CLOCK_PERIOD_NS;
  localparam int LEAD = int'(radio_ctrl_pkg::LEAD_STEP_CYC);
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  radio_ctrl_pkg::avl_req_t avl_req = '0;
  logic [31:0] avl_readdata;
  logic avl_waitrequest, pin = 1'b0, sel_b, fra, upload = 1'b0, sync_found = 1'b0;
  logic [3:0] rssi = 4'h0, intf = 4'h0, thr;
  logic frame_done = 1'b0, fcs_valid = 1'b0, ack_req = 1'b0, tx_done = 1'b0, rx_en, demod;
  logic ovr, prot, blocks, amp_on, data_en, eq_en, ov_seen = 1'b0;
  logic [2:0] gain;
  logic [1:0] goffs;
  logic signed [7:0] dbm;
  logic [7:0] rd, p;
  logic [1:0] md;
  int mismatches = 0, total_checks = 0, n, na, sy, seed = 32'hd191;
  radio_state_ctrl radio_state_ctrl_inst (.clock(clock), .rst_b(rst_b), .avl_req(avl_req),
    .avl_readdata(avl_readdata), .avl_waitrequest(avl_waitrequest), .sleep_transmit_pin(pin),
    .sel_b(sel_b), .frame_read_active(fra), .sync_found(sync_found), .rssi_level(rssi),
    .interference_level(intf), .frame_done(frame_done), .fcs_valid(fcs_valid),
    .ack_request(ack_req), .tx_done(tx_done), .rx_enable(rx_en), .demod_active(demod),
    .override_pulse(ovr), .frame_protected(prot), .tx_blocks_on(blocks), .amp_on(amp_on),
    .amp_gain(gain), .tx_data_en(data_en), .eq_enable(eq_en), .tx_power_dbm(dbm),
    .tx_gain_offset(goffs));
  host_model host_model_inst (.clock(clock), .rst_b(rst_b), .upload(upload), .sel_b(sel_b),
    .frame_read_active(fra));
  always #50 clock = ~clock;
  always @(posedge clock) if (ovr === 1'b1) ov_seen <= 1'b1;
  function automatic logic [7:0] pwr(input logic [4:0] v);
    return 8'(4 - int'(v));
  endfunction : pwr
  function automatic int sym_of(input logic [1:0] m);
    case (m)
      2'h0: return radio_ctrl_pkg::SYM_NS_BPSK20 / CP;
      2'h1: return radio_ctrl_pkg::SYM_NS_BPSK40 / CP;
      2'h2: return radio_ctrl_pkg::SYM_NS_OQPSK_LOW / CP;
      default: return radio_ctrl_pkg::SYM_NS_OQPSK_HIGH / CP;
    endcase
  endfunction : sym_of
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    avl_req <= '{read: !wr, write: wr, address: a, writedata: {24'h0, d}};
    do @(posedge clock); while (avl_waitrequest !== 1'b0);
    rd = avl_readdata[7:0];
    avl_req <= '0;
  endtask : bus
  task automatic st(input logic [4:0] c);
    bus(1'b0, 8'h04, 8'h00);
    chk(rd, {3'h0, c});
  endtask : st
  task automatic sync(input logic [3:0] r);
    sync_found <= 1'b1;
    rssi <= r;
    @(posedge clock);
    sync_found <= 1'b0;
    repeat (3) @(posedge clock);
  endtask : sync
  task automatic fdone(input logic f, input logic a);
    frame_done <= 1'b1;
    fcs_valid <= f;
    ack_req <= a;
    @(posedge clock);
    frame_done <= 1'b0;
    repeat (3) @(posedge clock);
  endtask : fdone
  task automatic txend(input logic [4:0] back);
    n = 0;
    while ((data_en !== 1'b1 || gain !== p[7:5]) && n < 999) begin
      @(posedge clock);
      n++;
    end
    chk({5'h0, gain}, {5'h0, p[7:5]});
    tx_done <= 1'b1;
    @(posedge clock);
    tx_done <= 1'b0;
    n = 0;
    while (amp_on !== 1'b0 && n < 200) begin
      @(posedge clock);
      n++;
    end
    chk({5'h0, gain}, 8'h00);
    chk({7'h0, blocks}, 8'h01);
    repeat (4) @(posedge clock);
    st(back);
    $display("transmit test done");
  endtask : txend
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_sim
  initial begin
    thr = 4'($random(seed)) | 4'h1;
    p = 8'($random(seed));
    md = 2'($random(seed));
    sy = sym_of(md);
    repeat (16) @(posedge clock);
    rst_b <= 1'b1;
    chk({7'h0, eq_en}, 8'h01);
    chk(dbm, 8'h04);
    bus(1'b1, 8'h08, {3'h0, radio_ctrl_pkg::CMD_TX_START});
    st(radio_ctrl_pkg::CODE_OFF);
    bus(1'b1, 8'h14, p);
    bus(1'b0, 8'h14, 8'h00);
    chk(rd, p);
    chk(dbm, pwr(p[4:0]));
    bus(1'b0, 8'hfc, 8'h00);
    chk(rd, 8'h00);
    bus(1'b1, 8'h58, 8'h07);
    bus(1'b1, 8'h30, {6'h20, md});
    bus(1'b1, 8'h54, {4'h0, thr});
    chk({7'h0, eq_en}, 8'h00);
    chk({6'h0, goffs}, 8'h03);
    bus(1'b1, 8'h08, {3'h0, radio_ctrl_pkg::CMD_RX_ON});
    st(radio_ctrl_pkg::CODE_RX_ON);
    chk({7'h0, rx_en}, 8'h01);
    sync(thr - 4'h1);
    chk({7'h0, demod}, 8'h00);
    sync(thr);
    st(radio_ctrl_pkg::CODE_BUSY_RX);
    intf <= 4'hf;
    @(posedge clock);
    sync(thr);
    chk({7'h0, ov_seen}, 8'h01);
    fdone(1'b1, 1'b0);
    chk({7'h0, prot}, 8'h01);
    st(radio_ctrl_pkg::CODE_RX_ON);
    sync(thr);
    chk({7'h0, demod}, 8'h00);
    upload <= 1'b1;
    @(posedge clock);
    upload <= 1'b0;
    repeat (24) @(posedge clock);
    chk({7'h0, prot}, 8'h00);
    sync(thr);
    fdone(1'b0, 1'b0);
    chk({7'h0, prot}, 8'h00);
    bus(1'b1, 8'h54, {4'h8, thr});
    sync(thr);
    chk({7'h0, demod}, 8'h00);
    bus(1'b1, 8'h54, {4'h0, thr});
    $display("receive tests done");
    bus(1'b1, 8'h08, {3'h0, radio_ctrl_pkg::CMD_PLL_ON});
    bus(1'b1, 8'h08, {3'h0, radio_ctrl_pkg::CMD_TX_START});
    n = 0;
    na = 0;
    while (data_en !== 1'b1 && n < 999) begin
      @(posedge clock);
      n++;
      if (amp_on === 1'b1 && na == 0) begin
        na = n;
        chk({5'h0, gain}, 8'h00);
      end
    end
    chk({7'h0, n inside {[sy:sy + 2]}}, 8'h01);
    chk({7'h0, (n - na) inside {[LEAD - 1:LEAD + 1]}}, 8'h01);
    st(radio_ctrl_pkg::CODE_BUSY_TX);
    txend(radio_ctrl_pkg::CODE_PLL_ON);
    pin <= 1'b1;
    repeat (5) @(posedge clock);
    st(radio_ctrl_pkg::CODE_BUSY_TX);
    txend(radio_ctrl_pkg::CODE_PLL_ON);
    pin <= 1'b0;
    bus(1'b1, 8'h30, {6'h00, md});
    bus(1'b1, 8'h08, {3'h0, radio_ctrl_pkg::CMD_AACK});
    st(radio_ctrl_pkg::CODE_AACK_ON);
    sync(thr);
    fdone(1'b1, 1'b1);
    chk({7'h0, blocks}, 8'h01);
    txend(radio_ctrl_pkg::CODE_AACK_ON);
    bus(1'b1, 8'h08, {3'h0, radio_ctrl_pkg::CMD_PLL_ON});
    bus(1'b1, 8'h08, {3'h0, radio_ctrl_pkg::CMD_ARET});
    st(radio_ctrl_pkg::CODE_ARET_ON);
    bus(1'b1, 8'h08, {3'h0, radio_ctrl_pkg::CMD_TRANSCEIVER_OFF_STATE});
    st(radio_ctrl_pkg::CODE_OFF);
    chk({7'h0, rx_en}, 8'h00);
    $display("state command test done");
    end_sim();
  end
  initial begin
    repeat (8000) @(posedge clock);
    mismatches++;
    end_sim();
  end
endmodule : radio_rx_tx_state_control_tb
